//--- logic/mgd_pkg.sv
// mgd_pkg: constants, register map, types and helpers of the gesture and motion detectors
// assumes samples arrive as 12-bit signed words on pclk with a one-cycle valid strobe
package mgd_pkg;
    localparam int AW = 12;
    localparam int SW = 13;
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_REMAP  = 8'h04;
    localparam logic [7:0]  OFS_MOTION = 8'h08;
    localparam logic [7:0]  OFS_STATUS = 8'h0c;
    localparam logic [7:0]  OFS_STATE  = 8'h10;
    localparam logic [11:0] RST_CTRL   = 12'h000;
    localparam logic [10:0] RST_REMAP  = 11'h210;
    localparam logic [11:0] RST_THR    = 12'h0a0;
    localparam logic [12:0] RST_DUR    = 13'h0004;
    // ctrl fields
    localparam int B_WRIST_EN  = 0;
    localparam int B_KNOCK_EN  = 1;
    localparam int B_SINGLE    = 2;
    localparam int B_SENS_LO   = 4;
    localparam int B_EN_X      = 8;
    localparam int B_NOMO_SEL  = 11;
    // motion register fields
    localparam int B_DUR_LO    = 16;
    // status bits
    localparam int S_WRIST  = 0;
    localparam int S_KNOCK  = 1;
    localparam int S_MOTION = 2;
    localparam int S_STILL  = 3;
    // detector constants, in samples and lsb
    localparam logic signed [11:0] WRIST_LEVEL = 12'sh0d5;
    localparam logic [7:0]  WRIST_HOLD  = 8'h19;
    localparam logic [11:0] KNOCK_BASE  = 12'h100;
    localparam logic [11:0] KNOCK_STEP  = 12'h040;
    localparam logic [7:0]  KNOCK_GAP   = 8'h03;
    localparam logic [7:0]  KNOCK_WIN   = 8'h28;
    localparam logic [12:0] CNT_MAX     = 13'h1fff;

    typedef enum logic {KN_IDLE, KN_ARMED} mgd_kn_st_t;

    function automatic logic [SW-1:0] mgd_abs(input logic signed [SW-1:0] v);
        return v[SW-1] ? SW'(-v) : SW'(v);
    endfunction : mgd_abs

    function automatic logic mgd_mapped(input logic [7:0] a);
        return a == OFS_CTRL || a == OFS_REMAP || a == OFS_MOTION || a == OFS_STATUS || a == OFS_STATE;
    endfunction : mgd_mapped
endpackage : mgd_pkg

//--- logic/mgd_remap.sv
// mgd_remap: axis remapping with source select and sign per output axis
// assumes selector and sign come from registers on the same clock
`timescale 1ns/10ps
module mgd_remap
    import mgd_pkg::*;
(
    input  wire logic [2:0][AW-1:0] acc,
    input  wire logic [5:0]         sel,
    input  wire logic [2:0]         sign,
    output logic      [2:0][AW-1:0] rem
);
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_axis
            logic signed [AW-1:0] src;
            always_comb begin
                src = (sel[2*i +: 2] == 2'h3) ? signed'(acc[i]) : signed'(acc[sel[2*i +: 2]]);
                if (sign[i] && src == 12'sh800) begin
                    rem[i] = 12'h7ff;
                end else if (sign[i]) begin
                    rem[i] = AW'(-src);
                end else begin
                    rem[i] = src;
                end
            end
        end
    endgenerate
endmodule : mgd_remap

//--- logic/mgd_slope.sv
// mgd_slope: slope engine for motion and stillness events
// assumes sample_valid is a one-cycle strobe on pclk
`timescale 1ns/10ps
module mgd_slope
    import mgd_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               sample_valid,
    input  wire logic [2:0][AW-1:0] acc,
    input  wire logic [2:0]         en,
    input  wire logic               nomo_sel,
    input  wire logic [AW-1:0]      thr,
    input  wire logic [12:0]        dur,
    output logic                    motion_evt,
    output logic                    still_evt,
    output logic                    motion_act
);
    typedef struct packed {
        logic [2:0][AW-1:0] refs;
        logic               ref_ok;
        logic [12:0]        cnt_hi;
        logic [12:0]        cnt_lo;
        logic               active;
        logic               still_done;
        logic               evt_m;
        logic               evt_s;
    } mgd_slope_st_t;

    mgd_slope_st_t s_q, s_d;
    logic [2:0]    exc;
    logic [12:0]   dur_e;

    always_comb begin
        s_d = s_q;
        s_d.evt_m = 1'b0;
        s_d.evt_s = 1'b0;
        dur_e = (dur == 13'h0) ? 13'h1 : dur;
        for (int i = 0; i < 3; i++) begin
            exc[i] = en[i] && (mgd_abs(SW'(signed'(acc[i])) - SW'(signed'(s_q.refs[i]))) > SW'(thr));
        end
        if (en == 3'h0) begin
            s_d = '0;
        end else if (sample_valid) begin
            if (!s_q.ref_ok) begin
                s_d.refs   = acc;
                s_d.ref_ok = 1'b1;
            end else begin
                s_d.cnt_hi = (|exc) ? ((s_q.cnt_hi == CNT_MAX) ? CNT_MAX : s_q.cnt_hi + 13'h1) : 13'h0;
                s_d.cnt_lo = (|exc) ? 13'h0 : ((s_q.cnt_lo == CNT_MAX) ? CNT_MAX : s_q.cnt_lo + 13'h1);
                if (!nomo_sel) begin
                    s_d.still_done = 1'b0;
                    if (!s_q.active && s_d.cnt_hi >= dur_e) begin
                        s_d.active = 1'b1;
                        s_d.evt_m  = 1'b1;
                    end else if (s_q.active && s_d.cnt_lo >= dur_e) begin
                        s_d.active = 1'b0;
                    end
                    if (s_d.active) begin
                        s_d.refs = acc;
                    end
                end else begin
                    s_d.active = 1'b0;
                    if (|exc) begin
                        s_d.still_done = 1'b0;
                        s_d.refs       = acc;
                    end else if (!s_q.still_done && s_d.cnt_lo >= dur_e) begin
                        s_d.still_done = 1'b1;
                        s_d.evt_s      = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign motion_evt = s_q.evt_m;
    assign still_evt  = s_q.evt_s;
    assign motion_act = s_q.active;

    property p_no_axis_quiet;
        @(posedge pclk) disable iff (!presetn) (en == 3'h0) |=> !motion_evt && !still_evt && !motion_act;
    endproperty
    a_no_axis_quiet: assert property (p_no_axis_quiet) else $error("slope event with no axis enabled");

    property p_motion_mode;
        @(posedge pclk) disable iff (!presetn) motion_evt |-> !$past(nomo_sel) && $past(sample_valid) && motion_act;
    endproperty
    a_motion_mode: assert property (p_motion_mode) else $error("motion event outside motion mode");

    property p_still_mode;
        @(posedge pclk) disable iff (!presetn) still_evt |-> $past(nomo_sel) && $past(sample_valid) && !motion_act;
    endproperty
    a_still_mode: assert property (p_still_mode) else $error("stillness event outside stillness mode");

    property p_clear_after_quiet;
        @(posedge pclk) disable iff (!presetn) $fell(motion_act) && !$past(nomo_sel) && $past(en) != 3'h0
            |-> $past(s_q.cnt_lo) + 13'h1 >= $past(dur_e);
    endproperty
    a_clear_after_quiet: assert property (p_clear_after_quiet) else $error("motion cleared too early");

    c_motion: cover property (@(posedge pclk) disable iff (!presetn) motion_evt);
    c_still:  cover property (@(posedge pclk) disable iff (!presetn) still_evt);
endmodule : mgd_slope

//--- logic/mgd_top.sv
// mgd_top: wrist gesture, knock and slope detectors with an apb register file
// assumes acc samples and sample_valid come from the data path on pclk
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module mgd_top
    import mgd_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          sample_valid,
    input  wire logic [AW-1:0] acc_x,
    input  wire logic [AW-1:0] acc_y,
    input  wire logic [AW-1:0] acc_z,
    output logic               feat_int
);
    typedef struct packed {
        logic [11:0]        ctrl;
        logic [10:0]        remap;
        logic [AW-1:0]      thr;
        logic [12:0]        dur;
        logic [3:0]         status;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic               irq;
        mgd_kn_st_t         kst;
        logic [7:0]         kwin;
        logic [AW-1:0]      zprev;
        logic               zok;
        logic [7:0]         wcnt;
        logic               wdone;
    } mgd_top_st_t;

    mgd_top_st_t        s_q, s_d;
    logic [2:0][AW-1:0] rem;
    logic               motion_evt;
    logic               still_evt;
    logic               motion_act;
    logic               acc_done;
    logic [3:0]         ev;
    logic [3:0]         clr;
    logic [AW-1:0]      kthr;
    logic               khit;

    mgd_remap u_remap (
        .acc  ({acc_z, acc_y, acc_x}),
        .sel  ({s_q.remap[9:8], s_q.remap[5:4], s_q.remap[1:0]}),
        .sign ({s_q.remap[10], s_q.remap[6], s_q.remap[2]}),
        .rem  (rem)
    );

    mgd_slope u_slope (
        .pclk         (pclk),
        .presetn      (presetn),
        .sample_valid (sample_valid),
        .acc          (rem),
        .en           (s_q.ctrl[B_EN_X +: 3]),
        .nomo_sel     (s_q.ctrl[B_NOMO_SEL]),
        .thr          (s_q.thr),
        .dur          (s_q.dur),
        .motion_evt   (motion_evt),
        .still_evt    (still_evt),
        .motion_act   (motion_act)
    );

    always_comb begin
        s_d = s_q;
        ev  = 4'h0;
        clr = 4'h0;
        acc_done = psel && penable && s_q.pready;
        // wrist gesture on the portrait-up axis
        if (!s_q.ctrl[B_WRIST_EN]) begin
            s_d.wcnt  = 8'h0;
            s_d.wdone = 1'b0;
        end else if (sample_valid) begin
            if (signed'(rem[1]) > WRIST_LEVEL) begin
                s_d.wcnt = (s_q.wcnt == WRIST_HOLD) ? WRIST_HOLD : s_q.wcnt + 8'h1;
                if (!s_q.wdone && s_q.wcnt + 8'h1 >= WRIST_HOLD) begin
                    ev[S_WRIST] = 1'b1;
                    s_d.wdone   = 1'b1;
                end
            end else begin
                s_d.wcnt  = 8'h0;
                s_d.wdone = 1'b0;
            end
        end
        // knock on the vertical axis
        kthr = KNOCK_BASE + AW'(s_q.ctrl[B_SENS_LO +: 3]) * KNOCK_STEP;
        khit = s_q.zok && (mgd_abs(SW'(signed'(rem[2])) - SW'(signed'(s_q.zprev))) > SW'(kthr));
        if (!s_q.ctrl[B_KNOCK_EN]) begin
            s_d.kst  = KN_IDLE;
            s_d.kwin = 8'h0;
            s_d.zok  = 1'b0;
        end else if (sample_valid) begin
            s_d.zprev = rem[2];
            s_d.zok   = 1'b1;
            unique case (s_q.kst)
                KN_IDLE: begin
                    if (khit && s_q.ctrl[B_SINGLE]) begin
                        ev[S_KNOCK] = 1'b1;
                    end else if (khit) begin
                        s_d.kst  = KN_ARMED;
                        s_d.kwin = 8'h0;
                    end
                end
                KN_ARMED: begin
                    s_d.kwin = s_q.kwin + 8'h1;
                    if (khit && s_q.kwin >= KNOCK_GAP) begin
                        ev[S_KNOCK] = 1'b1;
                        s_d.kst     = KN_IDLE;
                    end else if (s_q.kwin >= KNOCK_WIN) begin
                        s_d.kst = KN_IDLE;
                    end
                end
            endcase
        end
        ev[S_MOTION] = motion_evt;
        ev[S_STILL]  = still_evt;
        // apb slave: pready one cycle after setup
        s_d.pready  = psel && !penable;
        s_d.pslverr = psel && !penable && !mgd_mapped(paddr);
        s_d.prdata  = 32'h0;
        if (psel && !penable) begin
            unique case (paddr)
                OFS_CTRL:   s_d.prdata = 32'(s_q.ctrl);
                OFS_REMAP:  s_d.prdata = 32'(s_q.remap);
                OFS_MOTION: s_d.prdata = {3'h0, s_q.dur, 4'h0, s_q.thr};
                OFS_STATUS: s_d.prdata = 32'(s_q.status);
                OFS_STATE:  s_d.prdata = {29'h0, s_q.kst == KN_ARMED, s_q.wdone, motion_act};
                default:    s_d.prdata = 32'h0;
            endcase
        end else if (psel) begin
            s_d.prdata = s_q.prdata;
        end
        if (acc_done && pwrite) begin
            unique case (paddr)
                OFS_CTRL:   s_d.ctrl  = pwdata[11:0];
                OFS_REMAP:  s_d.remap = pwdata[10:0];
                OFS_MOTION: begin
                    s_d.thr = pwdata[AW-1:0];
                    s_d.dur = pwdata[B_DUR_LO +: 13];
                end
                default: ;
            endcase
        end
        if (acc_done && !pwrite && paddr == OFS_STATUS) begin
            clr = s_q.prdata[3:0];
        end
        s_d.status = (s_q.status & ~clr) | ev;
        s_d.irq    = |s_d.status;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q         <= '0;
            s_q.ctrl    <= RST_CTRL;
            s_q.remap   <= RST_REMAP;
            s_q.thr     <= RST_THR;
            s_q.dur     <= RST_DUR;
            s_q.kst     <= KN_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata   = s_q.prdata;
    assign pready   = s_q.pready;
    assign pslverr  = s_q.pslverr;
    assign feat_int = s_q.irq;

    property p_wrist_off;
        @(posedge pclk) disable iff (!presetn) !s_q.ctrl[B_WRIST_EN] |=> !$rose(s_q.status[S_WRIST]);
    endproperty
    a_wrist_off: assert property (p_wrist_off) else $error("wrist event while disabled");

    property p_knock_off;
        @(posedge pclk) disable iff (!presetn) !s_q.ctrl[B_KNOCK_EN] |=> !$rose(s_q.status[S_KNOCK]);
    endproperty
    a_knock_off: assert property (p_knock_off) else $error("knock event while disabled");

    property p_latched;
        @(posedge pclk) disable iff (!presetn) s_q.status[S_MOTION] && !acc_done |=> s_q.status[S_MOTION];
    endproperty
    a_latched: assert property (p_latched) else $error("event dropped without a read");

    property p_read_clear;
        @(posedge pclk) disable iff (!presetn)
            acc_done && !pwrite && paddr == OFS_STATUS && s_q.prdata[S_STILL] && !still_evt |=> !s_q.status[S_STILL];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

    property p_int_follow;
        @(posedge pclk) disable iff (!presetn)
            acc_done && !pwrite && paddr == OFS_STATUS && s_q.prdata[3:0] == s_q.status && ev == 4'h0 |=> !feat_int;
    endproperty
    a_int_follow: assert property (p_int_follow) else $error("interrupt line disagrees with status");

    property p_ready_setup;
        @(posedge pclk) disable iff (!presetn) psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready_setup: assert property (p_ready_setup) else $error("apb answer not one cycle after setup");

    property p_motion_bit;
        @(posedge pclk) disable iff (!presetn) motion_evt |=> s_q.status[S_MOTION] && feat_int;
    endproperty
    a_motion_bit: assert property (p_motion_bit) else $error("motion event not latched in its bit");

    property p_remap_id;
        @(posedge pclk) disable iff (!presetn) s_q.remap == RST_REMAP |-> rem == {acc_z, acc_y, acc_x};
    endproperty
    a_remap_id: assert property (p_remap_id) else $error("identity remap altered the axes");

    c_double_knock: cover property (@(posedge pclk) disable iff (!presetn) ev[S_KNOCK] && !s_q.ctrl[B_SINGLE]);
    c_wrist:        cover property (@(posedge pclk) disable iff (!presetn) ev[S_WRIST]);
    c_read_clear:   cover property (@(posedge pclk) disable iff (!presetn) clr != 4'h0);
endmodule : mgd_top

//--- verif/mgd_host.sv
// mgd_host: host processor model, an apb master that reads and writes the detector registers
// assumes its tasks are called just after a rising edge of pclk
`timescale 1ns/10ps
module mgd_host
    import mgd_pkg::*;
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // one transfer; a status read is how the host acknowledges events
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
endmodule : mgd_host

//--- verif/tb_top.sv
// tb_top: self-checking bench of the gesture and motion detectors
// assumes mgd_top on a 200 MHz pclk with the host model on its apb port
`timescale 1ns/10ps
module tb_top
    import mgd_pkg::*;
;
    typedef struct packed {
        logic [31:0] remap;
        logic [11:0] ax;
        logic [11:0] ay;
        logic [11:0] az;
        logic [31:0] st;
    } mgd_row_t;
    localparam mgd_row_t ROWS [7] = '{
        '{32'h0000_0210, 12'h000, 12'h100, 12'h000, 32'h0000_0001},
        '{32'h0000_0210, 12'h100, 12'h000, 12'h000, 32'h0000_0000},
        '{32'h0000_0200, 12'h100, 12'h000, 12'h000, 32'h0000_0001},
        '{32'h0000_0250, 12'h000, 12'hf00, 12'h000, 32'h0000_0001},
        '{32'h0000_0250, 12'h000, 12'h100, 12'h000, 32'h0000_0000},
        '{32'h0000_0220, 12'h000, 12'h000, 12'h100, 32'h0000_0001},
        '{32'h0000_0230, 12'h000, 12'h100, 12'h000, 32'h0000_0001}
    };
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sample_valid;
    logic [11:0] acc_x;
    logic [11:0] acc_y;
    logic [11:0] acc_z;
    logic        feat_int;
    logic [31:0] rdat;
    logic        rerr;
    int          error_cnt;
    int          num_checks;
    int          cycles;

    mgd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z), .feat_int(feat_int));
    mgd_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    task automatic chk32(input string name, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : chk32

    task automatic chk1(input string name, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", name, e, g);
        end
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rdat, rerr);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        u_host.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
    endtask : rd

    task automatic st(input logic [31:0] e);
        rd(OFS_STATUS);
        chk32("status", e, rdat);
    endtask : st

    // n samples, one every other cycle, then room for the event latency
    task automatic smp(input int n, input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        repeat (n) begin
            sample_valid <= 1'b1;
            acc_x <= x;
            acc_y <= y;
            acc_z <= z;
            @(posedge pclk);
            sample_valid <= 1'b0;
            @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
    endtask : smp

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        presetn = 1'b0;
        sample_valid = 1'b0;
        acc_x = 12'h000;
        acc_y = 12'h000;
        acc_z = 12'h000;
        error_cnt = 0;
        num_checks = 0;
        cycles = 0;
        repeat (4) @(posedge pclk);
        chk1("feat_int in reset", 1'b0, feat_int);
        chk1("pready in reset", 1'b0, pready);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_CTRL);
        chk32("ctrl reset", 32'h0000_0000, rdat);
        rd(OFS_REMAP);
        chk32("remap reset", 32'h0000_0210, rdat);
        rd(OFS_MOTION);
        chk32("motion reset", 32'h0004_00a0, rdat);
        rd(8'h14);
        chk1("unmapped error", 1'b1, rerr);
        chk32("unmapped data", 32'h0000_0000, rdat);
        foreach (ROWS[i]) begin
            wr(OFS_REMAP, ROWS[i].remap);
            wr(OFS_CTRL, 32'h0000_0001);
            smp(30, ROWS[i].ax, ROWS[i].ay, ROWS[i].az);
            st(ROWS[i].st);
            smp(3, 12'h000, 12'h000, 12'h000);
            st(32'h0000_0000);
        end
        // wrist gesture switched off
        wr(OFS_REMAP, 32'h0000_0210);
        wr(OFS_CTRL, 32'h0000_0000);
        smp(30, 12'h000, 12'h100, 12'h000);
        st(32'h0000_0000);
        smp(3, 12'h000, 12'h000, 12'h000);
        // slope engine with no axis enabled
        repeat (3) begin
            smp(1, 12'h100, 12'h000, 12'h000);
            smp(1, 12'h000, 12'h000, 12'h000);
        end
        st(32'h0000_0000);
        // motion on x, duration 2
        wr(OFS_MOTION, 32'h0002_00a0);
        wr(OFS_CTRL, 32'h0000_0100);
        smp(1, 12'h000, 12'h000, 12'h000);
        smp(2, 12'h100, 12'h000, 12'h000);
        chk1("feat_int raised", 1'b1, feat_int);
        repeat (20) @(posedge pclk);
        rd(OFS_STATE);
        chk1("motion active", 1'b1, rdat[0]);
        st(32'h0000_0004);
        repeat (2) @(posedge pclk);
        chk1("feat_int cleared", 1'b0, feat_int);
        smp(2, 12'h100, 12'h000, 12'h000);
        rd(OFS_STATE);
        chk1("motion released", 1'b0, rdat[0]);
        smp(1, 12'h200, 12'h000, 12'h000);
        smp(1, 12'h100, 12'h000, 12'h000);
        smp(1, 12'h200, 12'h000, 12'h000);
        st(32'h0000_0000);
        smp(1, 12'h200, 12'h000, 12'h000);
        st(32'h0000_0004);
        // stillness on x, then on x and y with y restless
        wr(OFS_CTRL, 32'h0000_0900);
        smp(4, 12'h200, 12'h000, 12'h000);
        st(32'h0000_0008);
        wr(OFS_CTRL, 32'h0000_0b00);
        repeat (4) begin
            smp(1, 12'h200, 12'h300, 12'h000);
            smp(1, 12'h200, 12'h000, 12'h000);
        end
        st(32'h0000_0000);
        // knock detector; the first enabled sample only sets the reference
        wr(OFS_CTRL, 32'h0000_0000);
        smp(1, 12'h000, 12'h000, 12'h300);
        st(32'h0000_0000);
        smp(1, 12'h000, 12'h000, 12'h000);
        wr(OFS_CTRL, 32'h0000_0006);
        smp(1, 12'h000, 12'h000, 12'h000);
        smp(1, 12'h000, 12'h000, 12'h180);
        st(32'h0000_0002);
        smp(1, 12'h700, 12'h700, 12'h180);
        st(32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0076);
        smp(1, 12'h000, 12'h000, 12'h000);
        st(32'h0000_0000);
        smp(1, 12'h000, 12'h000, 12'h300);
        st(32'h0000_0002);
        wr(OFS_CTRL, 32'h0000_0002);
        smp(1, 12'h000, 12'h000, 12'h000);
        smp(45, 12'h000, 12'h000, 12'h000);
        st(32'h0000_0000);
        smp(5, 12'h000, 12'h000, 12'h180);
        smp(1, 12'h000, 12'h000, 12'h000);
        st(32'h0000_0002);
        complete_run();
    end
endmodule : tb_top
